// [inc/zone_timer_map.svh]
// Register map, field layout, reset values and timing counts for the zone timers
//
// Contract
// - One jam timer covers arrival and sensor jams
// - Jam timer resets to 5 s, range 1-65
// - Jam held for auto-clear time, then reset
// - Auto-clear resets to 5 s, range 0-65
// - Motor runs run-after time after sensor clears
// - Run-after time per zone, 5 s, 0-65
// - Run-after measured in time or distance
// - Distance run-after resets 1000 mm, 0-65535
// - Zone accepts arrivals while run-after runs
`ifndef ZONE_TIMER_MAP_SVH
`define ZONE_TIMER_MAP_SVH

// ***********************************
// Register offsets (byte addresses)
// ***********************************
`define OFF_CTRL        12'h000
`define OFF_STATUS      12'h004
`define OFF_MASK        12'h008
`define OFF_STATE       12'h00C
`define OFF_JAM_UP      12'h010
`define OFF_CLR_UP      12'h014
`define OFF_RAT_UP      12'h018
`define OFF_RAD_UP      12'h01C
`define OFF_JAM_DN      12'h020
`define OFF_CLR_DN      12'h024
`define OFF_RAT_DN      12'h028
`define OFF_RAD_DN      12'h02C
`define ZONE_STRIDE     12'h010

// ***********************************
// Reset values and limits
// ***********************************
`define JAM_SEC_RST     16'h0005
`define JAM_SEC_MIN     16'h0001
`define JAM_SEC_MAX     16'h0041
`define CLR_SEC_RST     16'h0005
`define CLR_SEC_MAX     16'h0041
`define RAT_SEC_RST     16'h0005
`define RAT_SEC_MAX     16'h0041
`define RAD_MM_RST      16'h03E8

// ***********************************
// Timing
// ***********************************
`define CLK_HZ          40000000
`define TICKS_PER_SEC   `CLK_HZ

// ***********************************
// Status bit positions
// ***********************************
`define ST_ARR_UP       0
`define ST_SNS_UP       1
`define ST_CLR_UP       2
`define ST_ARR_DN       3
`define ST_SNS_DN       4
`define ST_CLR_DN       5
`define ST_WIDTH        6

`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// [inc/zone_timer_pkg.sv]
// Types shared by the zone timer design
package zone_timer_pkg;

  typedef enum logic [1:0] {
    ZS_IDLE   = 2'b00,
    ZS_CARRY  = 2'b01,
    ZS_RUNOUT = 2'b11,
    ZS_JAM    = 2'b10
  } zone_state_type;

  typedef struct packed {
    logic [15:0] jam_sec;
    logic [15:0] clr_sec;
    logic [15:0] rat_sec;
    logic [15:0] rad_mm;
    logic        dist_mode;
  } zone_cfg_type;

  typedef struct packed {
    logic arrival_jam;
    logic sensor_jam;
    logic jam_cleared;
  } zone_evt_type;

endpackage

// [verilog/zone_timer.sv]
// One conveyor zone: jam detection, auto clear and run-after of the roller motor
`include "zone_timer_map.svh"

module zone_timer #(
  parameter int unsigned TICKS_PER_SEC = `TICKS_PER_SEC
) (
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // Configuration
  input  wire zone_timer_pkg::zone_cfg_type cfg,
  // Zone inputs, already synchronised
  input  wire logic                         sensor_blocked,
  input  wire logic                         upstream_sending,
  input  wire logic                         downstream_ready,
  input  wire logic                         mm_pulse,
  // Zone outputs
  output logic                              roller_motor_r,
  output logic                              jam_r,
  output zone_timer_pkg::zone_state_type    state_r,
  output zone_timer_pkg::zone_evt_type      evt_r
);

  logic [31:0] tick_r;
  logic        sec_pulse;
  logic [15:0] sec_r;
  logic [15:0] mm_r;
  logic        sensor_d_r;
  logic        jam_limit;
  logic        clr_limit;
  logic        run_done;
  logic        moved;
  zone_timer_pkg::zone_state_type state_nxt;

  assign sec_pulse = (tick_r == 32'(TICKS_PER_SEC - 1));
  assign moved     = sensor_blocked != sensor_d_r;
  assign jam_limit = sec_pulse && (sec_r + 16'h0001 >= cfg.jam_sec);
  assign clr_limit = (cfg.clr_sec == 16'h0000) || (sec_pulse && (sec_r + 16'h0001 >= cfg.clr_sec));
  assign run_done  = cfg.dist_mode ? (mm_r >= cfg.rad_mm) : (sec_r >= cfg.rat_sec);

  // Second ticker, restarted on state change, movement outside a jam, or idle wait
  always_ff @(posedge aclk) begin
    if (!aresetn || state_nxt != state_r ||
        (moved && state_r != zone_timer_pkg::ZS_JAM) ||
        (state_r == zone_timer_pkg::ZS_IDLE && !upstream_sending)) begin
      tick_r <= 32'h0000_0000;
      sec_r  <= 16'h0000;
    end else if (sec_pulse) begin
      tick_r <= 32'h0000_0000;
      if (sec_r != 16'hFFFF) begin
        sec_r <= sec_r + 16'h0001;
      end
    end else begin
      tick_r <= tick_r + 32'h0000_0001;
    end
  end

  // Distance counter for run-after
  always_ff @(posedge aclk) begin
    if (!aresetn || state_r != zone_timer_pkg::ZS_RUNOUT) begin
      mm_r <= 16'h0000;
    end else if (mm_pulse && mm_r != 16'hFFFF) begin
      mm_r <= mm_r + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sensor_d_r <= 1'b0;
    end else begin
      sensor_d_r <= sensor_blocked;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      zone_timer_pkg::ZS_IDLE: begin
        if (sensor_blocked && downstream_ready) begin
          state_nxt = zone_timer_pkg::ZS_CARRY;
        end else if (upstream_sending && jam_limit) begin
          state_nxt = zone_timer_pkg::ZS_JAM;
        end
      end
      zone_timer_pkg::ZS_CARRY: begin
        if (!sensor_blocked) begin
          state_nxt = zone_timer_pkg::ZS_RUNOUT;
        end else if (jam_limit) begin
          state_nxt = zone_timer_pkg::ZS_JAM;
        end
      end
      zone_timer_pkg::ZS_RUNOUT: begin
        if (sensor_blocked) begin
          state_nxt = zone_timer_pkg::ZS_CARRY;
        end else if (run_done) begin
          state_nxt = zone_timer_pkg::ZS_IDLE;
        end
      end
      zone_timer_pkg::ZS_JAM: begin
        if (clr_limit) begin
          state_nxt = zone_timer_pkg::ZS_IDLE;
        end
      end
      default: state_nxt = zone_timer_pkg::ZS_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r        <= zone_timer_pkg::ZS_IDLE;
      roller_motor_r <= 1'b0;
      jam_r          <= 1'b0;
      evt_r          <= '0;
    end else begin
      state_r        <= state_nxt;
      roller_motor_r <= (state_nxt == zone_timer_pkg::ZS_RUNOUT) ||
                        (state_nxt == zone_timer_pkg::ZS_CARRY) ||
                        (state_nxt == zone_timer_pkg::ZS_IDLE && upstream_sending);
      jam_r          <= state_nxt == zone_timer_pkg::ZS_JAM;
      evt_r.arrival_jam <= state_r == zone_timer_pkg::ZS_IDLE &&
                           state_nxt == zone_timer_pkg::ZS_JAM;
      evt_r.sensor_jam  <= state_r == zone_timer_pkg::ZS_CARRY &&
                           state_nxt == zone_timer_pkg::ZS_JAM;
      evt_r.jam_cleared <= state_r == zone_timer_pkg::ZS_JAM &&
                           state_nxt == zone_timer_pkg::ZS_IDLE;
    end
  end

endmodule

// [verilog/conveyor_zone_jam_run_timer.sv]
// Two-zone conveyor timer top with AXI4-Lite register slave and interrupt
`include "zone_timer_map.svh"

module conveyor_zone_jam_run_timer #(
  parameter int unsigned TICKS_PER_SEC = `TICKS_PER_SEC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Zone pins, upstream index 0, downstream index 1
  input  wire logic [1:0]  sensor_blocked_pin,
  input  wire logic [1:0]  upstream_sending_pin,
  input  wire logic [1:0]  downstream_ready_pin,
  input  wire logic [1:0]  mm_pulse_pin,
  output logic [1:0]       roller_motor,
  output logic [1:0]       jam,
  // Interrupt
  output logic             irq
);

  // ***********************************
  // Input synchronisers
  // ***********************************
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic [1:0] mm_d_r;
  logic [1:0] mm_edge;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      mm_d_r   <= 2'b00;
    end else begin
      pin_s1_r <= {mm_pulse_pin, downstream_ready_pin, upstream_sending_pin,
                   sensor_blocked_pin};
      pin_s2_r <= pin_s1_r;
      mm_d_r   <= pin_s2_r[7:6];
    end
  end
  assign mm_edge = pin_s2_r[7:6] & ~mm_d_r;

  // ***********************************
  // Configuration registers
  // ***********************************
  zone_timer_pkg::zone_cfg_type   cfg_r [2];
  zone_timer_pkg::zone_state_type state_w [2];
  zone_timer_pkg::zone_evt_type   evt_w [2];
  logic [1:0]                     motor_w;
  logic [1:0]                     jam_w;
  logic [`ST_WIDTH-1:0]           status_r;
  logic [`ST_WIDTH-1:0]           mask_r;
  logic [`ST_WIDTH-1:0]           events;
  logic [`ST_WIDTH-1:0]           clr_bits;

  // ***********************************
  // Write channel
  // ***********************************
  logic        aw_held_r;
  logic        w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_fire;
  logic        wr_hit;
  logic [15:0] wval;

  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wval    = wdata_r[15:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 12'h000;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_hit = 1'b0;
    case ({awaddr_r[11:2], 2'b00})
      `OFF_CTRL, `OFF_STATUS, `OFF_MASK, `OFF_STATE: wr_hit = 1'b1;
      `OFF_JAM_UP, `OFF_CLR_UP, `OFF_RAT_UP, `OFF_RAD_UP: wr_hit = 1'b1;
      `OFF_JAM_DN, `OFF_CLR_DN, `OFF_RAT_DN, `OFF_RAD_DN: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Per-zone settings with range limits
  generate
    for (genvar z = 0; z < 2; z++) begin : g_cfg
      localparam logic [11:0] BASE = `OFF_JAM_UP + 12'(z) * `ZONE_STRIDE;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cfg_r[z].jam_sec   <= `JAM_SEC_RST;
          cfg_r[z].clr_sec   <= `CLR_SEC_RST;
          cfg_r[z].rat_sec   <= `RAT_SEC_RST;
          cfg_r[z].rad_mm    <= `RAD_MM_RST;
          cfg_r[z].dist_mode <= 1'b0;
        end else if (wr_fire && (&wstrb_r[1:0])) begin
          if ({awaddr_r[11:2], 2'b00} == BASE &&
              wval >= `JAM_SEC_MIN && wval <= `JAM_SEC_MAX) begin
            cfg_r[z].jam_sec <= wval;
          end
          if ({awaddr_r[11:2], 2'b00} == BASE + 12'h004 && wval <= `CLR_SEC_MAX) begin
            cfg_r[z].clr_sec <= wval;
          end
          if ({awaddr_r[11:2], 2'b00} == BASE + 12'h008 && wval <= `RAT_SEC_MAX) begin
            cfg_r[z].rat_sec <= wval;
          end
          if ({awaddr_r[11:2], 2'b00} == BASE + 12'h00C) begin
            cfg_r[z].rad_mm <= wval;
          end
          if ({awaddr_r[11:2], 2'b00} == `OFF_CTRL) begin
            cfg_r[z].dist_mode <= wdata_r[z];
          end
        end
      end

      zone_timer #(
        .TICKS_PER_SEC (TICKS_PER_SEC)
      ) u_zone (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .cfg              (cfg_r[z]),
        .sensor_blocked   (pin_s2_r[z]),
        .upstream_sending (pin_s2_r[2+z]),
        .downstream_ready (pin_s2_r[4+z]),
        .mm_pulse         (mm_edge[z]),
        .roller_motor_r   (motor_w[z]),
        .jam_r            (jam_w[z]),
        .state_r          (state_w[z]),
        .evt_r            (evt_w[z])
      );
    end
  endgenerate

  assign roller_motor = motor_w;
  assign jam          = jam_w;
  assign events       = {evt_w[1].jam_cleared, evt_w[1].sensor_jam, evt_w[1].arrival_jam,
                         evt_w[0].jam_cleared, evt_w[0].sensor_jam, evt_w[0].arrival_jam};

  // ***********************************
  // Status and mask
  // ***********************************
  assign clr_bits = (wr_fire && wstrb_r[0] && {awaddr_r[11:2], 2'b00} == `OFF_STATUS) ?
                    wdata_r[`ST_WIDTH-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
      mask_r   <= '0;
      irq      <= 1'b0;
    end else begin
      status_r <= (status_r & ~clr_bits) | events;
      if (wr_fire && wstrb_r[0] && {awaddr_r[11:2], 2'b00} == `OFF_MASK) begin
        mask_r <= wdata_r[`ST_WIDTH-1:0];
      end
      irq <= |(((status_r & ~clr_bits) | events) & mask_r);
    end
  end

  // ***********************************
  // Read channel
  // ***********************************
  logic [31:0] rd_val;
  logic        rd_hit;
  logic [11:0] ra;

  assign ra = {s_axi_araddr[11:2], 2'b00};

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (ra)
      `OFF_CTRL:   rd_val = {30'h0, cfg_r[1].dist_mode, cfg_r[0].dist_mode};
      `OFF_STATUS: rd_val = {26'h0, status_r};
      `OFF_MASK:   rd_val = {26'h0, mask_r};
      `OFF_STATE:  rd_val = {24'h0, motor_w, jam_w, state_w[1], state_w[0]};
      `OFF_JAM_UP: rd_val = {16'h0, cfg_r[0].jam_sec};
      `OFF_CLR_UP: rd_val = {16'h0, cfg_r[0].clr_sec};
      `OFF_RAT_UP: rd_val = {16'h0, cfg_r[0].rat_sec};
      `OFF_RAD_UP: rd_val = {16'h0, cfg_r[0].rad_mm};
      `OFF_JAM_DN: rd_val = {16'h0, cfg_r[1].jam_sec};
      `OFF_CLR_DN: rd_val = {16'h0, cfg_r[1].clr_sec};
      `OFF_RAT_DN: rd_val = {16'h0, cfg_r[1].rat_sec};
      `OFF_RAD_DN: rd_val = {16'h0, cfg_r[1].rad_mm};
      default:     rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// [verification/zone_timer_properties.sv]
// Concurrent checks on the zone timer top ports
module zone_timer_properties #(
  parameter int unsigned TICKS_PER_SEC = 10
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Bus handshakes
  input  wire logic       s_axi_awready,
  input  wire logic       s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic       s_axi_arvalid,
  input  wire logic       s_axi_arready,
  input  wire logic       s_axi_rvalid,
  input  wire logic       s_axi_rready,
  // Zone pins
  input  wire logic [1:0] sensor_blocked_pin,
  input  wire logic [1:0] upstream_sending_pin,
  input  wire logic [1:0] roller_motor,
  input  wire logic [1:0] jam,
  input  wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************
  // Sensor stability counter
  // ****************************
  int unsigned stab_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || $changed(sensor_blocked_pin[0])) begin
      stab_r <= 0;
    end else begin
      stab_r <= stab_r + 1;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence jam_start;
    $rose(jam[0]);
  endsequence
  sequence jam_gone;
    ##[1:700] !jam[0];
  endsequence
  // ****************************
  // Assertions
  // ****************************
  a_reset_quiet: assert property ($rose(aresetn) |-> jam == 2'b00 && roller_motor == 2'b00 && !irq)
    else $error("outputs active after reset");
  a_jam_release: assert property (jam_start |-> jam_gone)
    else $error("upstream jam never released");
  a_dn_release: assert property ($rose(jam[1]) |-> ##[1:700] !jam[1])
    else $error("downstream jam never released");
  a_jam_wait: assert property (jam_start |-> stab_r >= TICKS_PER_SEC - 2)
    else $error("jam raised before one jam period");
  a_jam_motor: assert property (jam[0] && $past(jam[0]) |-> !roller_motor[0])
    else $error("roller runs while jam held");
  a_runout_end: assert property (roller_motor[0] && !sensor_blocked_pin[0] &&
    !upstream_sending_pin[0] |-> ##[0:700] !roller_motor[0])
    else $error("roller never stops after run-after");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
endmodule

// [verification/zone_field_model.sv]
// Field model: zone sensors, neighbour handshakes and roller encoders
module zone_field_model (
  // Clock
  input  wire logic       aclk,
  // Bench commands
  input  wire logic [1:0] blocked_cmd,
  input  wire logic [1:0] sending_cmd,
  input  wire logic [1:0] ready_cmd,
  // Zone pins
  input  wire logic [1:0] roller_motor,
  output logic      [1:0] sensor_blocked_pin,
  output logic      [1:0] upstream_sending_pin,
  output logic      [1:0] downstream_ready_pin,
  output logic      [1:0] mm_pulse_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sensor_blocked_pin = 2'b00;
    upstream_sending_pin = 2'b00;
    downstream_ready_pin = 2'b00;
    mm_pulse_pin = 2'b00;
  end
  // Sensors follow cartons, encoder edge every second cycle while turning
  always @(posedge aclk) begin
    sensor_blocked_pin <= blocked_cmd;
    upstream_sending_pin <= sending_cmd;
    downstream_ready_pin <= ready_cmd;
    mm_pulse_pin <= roller_motor & ~mm_pulse_pin;
  end
endmodule

// [verification/conveyor_zone_jam_run_timer_tb_top.sv]
// Self-checking bench for the two-zone jam and run-after timer
`include "zone_timer_map.svh"
module conveyor_zone_jam_run_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned T = 10;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [1:0]  blk = 2'b00, snd = 2'b00, rdy = 2'b00;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, sb, us, dr, mp, motor, jam;
  logic [31:0] rdata;
  int          n_fail = 0;
  int          n_tests = 0;
  always #12.5 aclk = ~aclk;
  conveyor_zone_jam_run_timer #(.TICKS_PER_SEC(T)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .sensor_blocked_pin(sb),
    .upstream_sending_pin(us), .downstream_ready_pin(dr), .mm_pulse_pin(mp),
    .roller_motor(motor), .jam(jam), .irq(irq));
  zone_field_model field_u (.aclk(aclk), .blocked_cmd(blk), .sending_cmd(snd),
    .ready_cmd(rdy), .roller_motor(motor), .sensor_blocked_pin(sb),
    .upstream_sending_pin(us), .downstream_ready_pin(dr), .mm_pulse_pin(mp));
  // ****************************
  // Shared tasks
  // ****************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    $display("MISMATCH wait expected answer seen none");
    end_of_test();
  endtask
  task automatic rng(input string nm, input int n, input int lo, input int hi);
    chk(nm, {31'h0, n >= lo && n <= hi}, 32'h0000_0001);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 50) hang();
    bready <= 1'b0;
    r = bresp;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 50) hang();
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, d, e);
  endtask
  task automatic pins(input logic [1:0] b, input logic [1:0] s, input logic [1:0] r);
    @(posedge aclk);
    blk <= b;
    snd <= s;
    rdy <= r;
  endtask
  task automatic wait_for(input bit is_jam, input int z, input logic v, output int n);
    for (n = 0; n < 2000; n++) begin
      @(posedge aclk);
      if ((is_jam ? jam[z] : motor[z]) === v) return;
    end
    hang();
  endtask
  // ****************************
  // Scenarios
  // ****************************
  task automatic t_defaults();
    logic [31:0] d;
    logic [1:0]  r;
    rc("jam up", `OFF_JAM_UP, {16'h0000, `JAM_SEC_RST});
    rc("clr dn", `OFF_CLR_DN, {16'h0000, `CLR_SEC_RST});
    rc("rat up", `OFF_RAT_UP, 32'h0000_0005);
    rc("rat dn", `OFF_RAT_DN, 32'h0000_0005);
    rc("rad up", `OFF_RAD_UP, 32'h0000_03E8);
    rc("mode", `OFF_CTRL, 32'h0000_0000);
    rd(12'h030, d, r);
    chk("rresp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    wr(12'h030, 32'h0000_0001, r);
    chk("bresp", {30'h0, r}, {30'h0, `RESP_SLVERR});
  endtask
  task automatic t_ranges();
    logic [11:0] a [6] = '{`OFF_JAM_UP, `OFF_JAM_UP, `OFF_JAM_UP, `OFF_CLR_UP, `OFF_RAT_DN,
                           `OFF_RAD_DN};
    logic [31:0] d [6] = '{32'h0000_0000, 32'h0000_0041, 32'h0000_0042, 32'h0000_0000,
                           32'h0000_0042, 32'h0000_FFFF};
    logic [31:0] e [6] = '{32'h0000_0005, 32'h0000_0041, 32'h0000_0041, 32'h0000_0000,
                           32'h0000_0005, 32'h0000_FFFF};
    for (int i = 0; i < 6; i++) begin
      w(a[i], d[i]);
      rc("range", a[i], e[i]);
    end
  endtask
  task automatic t_sensor_jam();
    int n;
    w(`OFF_JAM_UP, 32'h0000_0001);
    w(`OFF_CLR_UP, 32'h0000_0001);
    w(`OFF_MASK, 32'h0000_003F);
    pins(2'b01, 2'b00, 2'b01);
    wait_for(1, 0, 1'b1, n);
    pins(2'b00, 2'b00, 2'b00);
    wait_for(1, 0, 1'b0, n);
    rng("hold", n, 7, 9);
    rc("status", `OFF_STATUS, 32'h0000_0006);
    rc("state", `OFF_STATE, 32'h0000_0000);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    w(`OFF_MASK, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    w(`OFF_STATUS, 32'h0000_003F);
    w(`OFF_MASK, 32'h0000_003F);
    rc("cleared", `OFF_STATUS, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chk("irq clear", {31'h0, irq}, 32'h0000_0000);
    pins(2'b01, 2'b00, 2'b01);
    wait_for(1, 0, 1'b1, n);
    rng("restart", n, 10, 16);
    pins(2'b00, 2'b00, 2'b00);
    wait_for(1, 0, 1'b0, n);
  endtask
  task automatic t_arrival();
    int n;
    w(`OFF_JAM_DN, 32'h0000_0001);
    w(`OFF_CLR_DN, 32'h0000_0002);
    w(`OFF_STATUS, 32'h0000_003F);
    pins(2'b00, 2'b10, 2'b00);
    wait_for(0, 1, 1'b1, n);
    wait_for(1, 1, 1'b1, n);
    rng("arrive", n, 7, 9);
    pins(2'b00, 2'b00, 2'b00);
    wait_for(1, 1, 1'b0, n);
    rng("hold dn", n, 13, 22);
    rc("arrival", `OFF_STATUS, 32'h0000_0028);
    w(`OFF_STATUS, 32'h0000_003F);
  endtask
  task automatic t_runafter();
    int n;
    w(`OFF_JAM_UP, 32'h0000_0041);
    w(`OFF_RAT_UP, 32'h0000_0002);
    pins(2'b01, 2'b00, 2'b01);
    wait_for(0, 0, 1'b1, n);
    pins(2'b00, 2'b00, 2'b01);
    repeat (6) @(posedge aclk);
    pins(2'b01, 2'b00, 2'b01);
    repeat (4) @(posedge aclk);
    rc("accept", `OFF_STATE, 32'h0000_0041);
    pins(2'b00, 2'b00, 2'b01);
    wait_for(0, 0, 1'b0, n);
    rng("run after", n, 19, 25);
  endtask
  task automatic t_distance();
    int n;
    w(`OFF_CTRL, 32'h0000_0001);
    w(`OFF_RAD_UP, 32'h0000_0005);
    w(`OFF_RAT_UP, 32'h0000_0041);
    pins(2'b01, 2'b00, 2'b01);
    wait_for(0, 0, 1'b1, n);
    pins(2'b00, 2'b00, 2'b01);
    wait_for(0, 0, 1'b0, n);
    rng("run mm", n, 8, 24);
    w(`OFF_CTRL, 32'h0000_0000);
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults();
    t_ranges();
    t_sensor_jam();
    t_arrival();
    t_runafter();
    t_distance();
    end_of_test();
  end
endmodule
bind conveyor_zone_jam_run_timer zone_timer_properties #(.TICKS_PER_SEC(TICKS_PER_SEC)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .sensor_blocked_pin(sensor_blocked_pin), .upstream_sending_pin(upstream_sending_pin),
  .roller_motor(roller_motor), .jam(jam), .irq(irq));
